// ---- hdl/dba_pkg.sv ----
// package: constants, types and register map of the drive bus adapter
package dba_pkg;
    localparam int DBA_CLK_MHZ = 200;
    // time constants in ns and us and derived cycle counts
    localparam int DBA_DESKEW_NS = 50;
    localparam logic [7:0] DBA_DESKEW_RST = 8'((DBA_DESKEW_NS * DBA_CLK_MHZ + 999) / 1000);
    localparam int DBA_TIMEOUT_US = 100;
    localparam int DBA_TIMEOUT_CYC = DBA_TIMEOUT_US * DBA_CLK_MHZ;
    // register offsets on the plain port
    localparam logic [3:0] DBA_REG_CMD = 4'h0;
    localparam logic [3:0] DBA_REG_ACC = 4'h1;
    localparam logic [3:0] DBA_REG_STAT = 4'h2;
    localparam logic [3:0] DBA_REG_RDATA = 4'h3;
    localparam logic [3:0] DBA_REG_DESKEW = 4'h4;
    localparam logic [3:0] DBA_REG_WDATA = 4'h5;
    localparam logic [3:0] DBA_REG_RDWORD = 4'h6;
    // status bit positions
    localparam int DBA_ST_BUSY = 31;
    localparam int DBA_ST_MXF = 30;
    localparam int DBA_ST_EXC = 29;
    localparam int DBA_ST_ATTENTION_LINE = 28;
    localparam int DBA_ST_CPE = 27;
    localparam int DBA_ST_CBUSY = 26;
    localparam int DBA_ST_RDV = 25;
    localparam int DBA_ST_WRQ = 24;
    localparam int DBA_ST_DIR = 23;
    // command codes: bit 0 is the go bit
    localparam logic [5:0] DBA_DATA_CMD_MIN = 6'h29;
    localparam logic [5:0] DBA_DATA_CMD_MAX = 6'h3f;
    localparam int DBA_SYNC_STAGES = 2;

    typedef struct packed {
        logic [2:0] drive_select;
        logic [4:0] register_select;
        logic direction_line;
    } dba_addr_t;

    typedef struct packed {
        logic [15:0] data;
        logic parity;
    } dba_word_t;

    function automatic logic dba_odd_par(input logic [15:0] d);
        dba_odd_par = ~(^d);
    endfunction : dba_odd_par
endpackage : dba_pkg

// ---- hdl/dba_sync.sv ----
// two-flop synchroniser for a bus of pin inputs
`timescale 1ns/1ps
module dba_sync #(
    parameter int W = 1
) (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] stage1;
    logic [W-1:0] next_stage1;
    logic [W-1:0] next_sync;

    always_comb begin
        next_stage1 = async_i;
        next_sync = stage1;
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            stage1 <= '0;
            sync_o <= '0;
        end else begin
            stage1 <= next_stage1;
            sync_o <= next_sync;
        end
    end
endmodule : dba_sync

// ---- hdl/dba_ctl_hs.sv ----
// control bus demand/transfer handshake engine
`timescale 1ns/1ps
module dba_ctl_hs
    import dba_pkg::*;
(
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic start_i,
    input wire dba_addr_t addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic [7:0] deskew_i,
    input wire logic transfer_ack_i,
    input wire dba_word_t ctl_in_i,
    output dba_addr_t addr_o,
    output dba_word_t ctl_out_o,
    output logic ctl_oe_o,
    output logic demand_strobe_o,
    output logic busy_o,
    output logic done_o,
    output logic [15:0] rdata_o,
    output logic par_err_o
);
    typedef enum logic [2:0] {HS_IDLE, HS_SETTLE, HS_WAIT_ACK, HS_HOLD, HS_WAIT_REL} dba_hs_t;
    dba_hs_t state, next_state;
    logic [7:0] cnt, next_cnt;
    dba_addr_t next_addr;
    dba_word_t next_ctl_out;
    logic next_oe, next_dem, next_done, next_perr;
    logic [15:0] next_rdata;

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_addr = addr_o;
        next_ctl_out = ctl_out_o;
        next_oe = ctl_oe_o;
        next_dem = demand_strobe_o;
        next_done = 1'b0;
        next_rdata = rdata_o;
        next_perr = par_err_o;
        case (state)
            HS_IDLE: begin
                if (start_i) begin
                    next_addr = addr_i;
                    next_ctl_out = '{data: wdata_i, parity: dba_odd_par(wdata_i)};
                    next_oe = addr_i.direction_line;
                    next_cnt = deskew_i;
                    next_state = HS_SETTLE;
                end
            end
            HS_SETTLE: begin
                if (cnt <= 8'h01) begin
                    next_dem = 1'b1;
                    next_state = HS_WAIT_ACK;
                end else begin
                    next_cnt = cnt - 8'h01;
                end
            end
            HS_WAIT_ACK: begin
                if (transfer_ack_i) begin
                    if (addr_o.direction_line) begin
                        next_dem = 1'b0;
                        next_state = HS_WAIT_REL;
                    end else begin
                        next_rdata = ctl_in_i.data;
                        next_perr = (ctl_in_i.parity != dba_odd_par(ctl_in_i.data));
                        next_cnt = deskew_i;
                        next_state = HS_HOLD;
                    end
                end
            end
            HS_HOLD: begin
                if (cnt <= 8'h01) begin
                    next_dem = 1'b0;
                    next_state = HS_WAIT_REL;
                end else begin
                    next_cnt = cnt - 8'h01;
                end
            end
            HS_WAIT_REL: begin
                if (!transfer_ack_i) begin
                    next_oe = 1'b0;
                    next_done = 1'b1;
                    next_state = HS_IDLE;
                end
            end
            default: next_state = HS_IDLE;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            state <= HS_IDLE;
            cnt <= 8'h00;
            addr_o <= '0;
            ctl_out_o <= '0;
            ctl_oe_o <= 1'b0;
            demand_strobe_o <= 1'b0;
            done_o <= 1'b0;
            rdata_o <= 16'h0000;
            par_err_o <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            addr_o <= next_addr;
            ctl_out_o <= next_ctl_out;
            ctl_oe_o <= next_oe;
            demand_strobe_o <= next_dem;
            done_o <= next_done;
            rdata_o <= next_rdata;
            par_err_o <= next_perr;
        end
    end

    assign busy_o = (state != HS_IDLE);
endmodule : dba_ctl_hs

// ---- hdl/dba_top.sv ----
// drive bus adapter: command start, register access and sector data transfer
`timescale 1ns/1ps
// Overview of operation
// - command word carries function code and go
// - code in bits 5..0, data codes 29-3f
// - busy flag set when data command written
// - occupied first, then run, then words move
// - exception seen: drop run
// - select lines settle, then demand after deskew
// - read: capture, deskew, drop demand, ack drops
// - read data handed to requester when complete
// - read word: drive data low, status high
// - write: data with demand, ack, release
// - register reads allowed during data transfer
// - after run, wait for sync clock
// - one word per write/sync clock pulse
// - end-of-block: continue if run else stop
// - odd parity over control lines both ways
// - missing occupied/sync clock sets missed transfer
// - sample read at sync fall; echo write clock
module dba_top
    import dba_pkg::*;
#(
    parameter int TIMEOUT_CYC = DBA_TIMEOUT_CYC
) (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    output dba_addr_t ctl_addr_o,
    input wire dba_word_t ctl_i,
    output dba_word_t ctl_o,
    output logic ctl_oe_o,
    output logic demand_strobe_o,
    input wire logic transfer_ack_i,
    input wire logic attention_line_i,
    output logic run_o,
    input wire logic occupied_line_i,
    input wire logic exception_line_i,
    input wire logic end_of_block_pulse_i,
    input wire logic sync_clk_i,
    output logic write_clk_o,
    input wire dba_word_t data_i,
    output dba_word_t data_o,
    output logic data_oe_o
);
    // ************************************************************
    // pin synchronisers
    // ************************************************************
    localparam int NSYNC = 24;
    logic [NSYNC-1:0] pins_s;
    logic ack_s, attention_line_s, occ_s, exc_s, ebl_s, sclk_s;
    dba_word_t ctl_s, din_s;

    // wide buses are stable before their strobes, so per-bit sync is safe here
    dba_sync #(.W(NSYNC)) u_sync_ctl (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .async_i({ctl_i[16:0], transfer_ack_i, attention_line_i, occupied_line_i,
                  exception_line_i, end_of_block_pulse_i, sync_clk_i, 1'b0}),
        .sync_o(pins_s)
    );
    logic [16:0] din_raw;
    dba_sync #(.W(17)) u_sync_dat (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .async_i(data_i),
        .sync_o(din_raw)
    );
    assign ctl_s = pins_s[23:7];
    assign ack_s = pins_s[6];
    assign attention_line_s = pins_s[5];
    assign occ_s = pins_s[4];
    assign exc_s = pins_s[3];
    assign ebl_s = pins_s[2];
    assign sclk_s = pins_s[1];
    assign din_s = din_raw;

    // ************************************************************
    // register port and control bus access
    // ************************************************************
    logic wr_cmd, wr_acc, hs_busy, hs_done, hs_perr;
    logic [15:0] hs_rdata;
    dba_addr_t acc_addr;
    logic [7:0] deskew, next_deskew;
    logic [15:0] wdata_reg, next_wdata_reg;
    logic busy, next_busy, missed_transfer_error, next_mxf, exc_seen, next_exc_seen, cpe, next_cpe;
    logic rd_valid, next_rd_valid, run_next, wcnt_hi;
    logic [31:0] next_rdata;
    logic [15:0] word_cnt, next_word_cnt;
    logic [15:0] rd_word, next_rd_word;
    logic dir_write, next_dir_write;
    logic [5:0] cmd_code;
    logic is_data_cmd;
    logic [31:0] status;

    assign wr_cmd = reg_wr_i && reg_addr_i == DBA_REG_CMD && !hs_busy;
    assign wr_acc = reg_wr_i && reg_addr_i == DBA_REG_ACC && !hs_busy;
    assign cmd_code = reg_wdata_i[5:0];
    // data command only counts with go set
    assign is_data_cmd = cmd_code[0] && cmd_code >= DBA_DATA_CMD_MIN;
    assign acc_addr = wr_cmd ? '{drive_select: reg_wdata_i[10:8], register_select: 5'h00,
                                 direction_line: 1'b1}
                             : '{drive_select: reg_wdata_i[10:8],
                                 register_select: reg_wdata_i[4:0],
                                 direction_line: reg_wdata_i[16]};

    // command register write goes out as a write to drive register 0
    dba_ctl_hs u_hs (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .start_i(wr_cmd || wr_acc),
        .addr_i(acc_addr),
        .wdata_i(wr_cmd ? {10'h000, cmd_code} : wdata_reg),
        .deskew_i(deskew),
        .transfer_ack_i(ack_s),
        .ctl_in_i(ctl_s),
        .addr_o(ctl_addr_o),
        .ctl_out_o(ctl_o),
        .ctl_oe_o(ctl_oe_o),
        .demand_strobe_o(demand_strobe_o),
        .busy_o(hs_busy),
        .done_o(hs_done),
        .rdata_o(hs_rdata),
        .par_err_o(hs_perr)
    );

    // ************************************************************
    // data transfer sequencer
    // ************************************************************
    typedef enum logic [2:0] {DT_IDLE, DT_WAIT_OCC, DT_RUN, DT_WAIT_EBL} dba_dt_t;
    dba_dt_t dt, next_dt;
    logic [31:0] tmo, next_tmo;
    logic sclk_d, ebl_d, next_run, next_wclk, next_doe;
    dba_word_t next_dout;
    logic sclk_rise, sclk_fall, ebl_fall;

    assign sclk_rise = sclk_s && !sclk_d;
    assign sclk_fall = !sclk_s && sclk_d;
    assign ebl_fall = !ebl_s && ebl_d;
    assign wcnt_hi = (word_cnt != 16'h0000);

    always_comb begin
        next_dt = dt;
        next_tmo = tmo;
        next_run = run_o;
        next_busy = busy;
        next_mxf = missed_transfer_error;
        next_exc_seen = exc_seen || exc_s;
        next_wclk = 1'b0;
        next_doe = data_oe_o;
        next_dout = data_o;
        next_word_cnt = word_cnt;
        next_rd_word = rd_word;
        next_dir_write = dir_write;
        run_next = 1'b0;
        case (dt)
            DT_IDLE: begin
                if (wr_cmd && is_data_cmd) begin
                    next_busy = 1'b1;
                    next_mxf = 1'b0;
                    next_exc_seen = exc_s;
                    next_dir_write = reg_wdata_i[16];
                    next_word_cnt = reg_wdata_i[31:16] == 16'h0000 ? 16'hffff
                                                                     : reg_wdata_i[31:16];
                    next_tmo = 32'(TIMEOUT_CYC);
                    next_dt = DT_WAIT_OCC;
                end
            end
            DT_WAIT_OCC: begin
                if (occ_s) begin
                    next_run = 1'b1;
                    next_doe = dir_write;
                    next_dout = '{data: wdata_reg, parity: dba_odd_par(wdata_reg)};
                    next_tmo = 32'(TIMEOUT_CYC);
                    next_dt = DT_RUN;
                end else if (tmo == 32'h0) begin
                    next_mxf = 1'b1;
                    next_busy = 1'b0;
                    next_dt = DT_IDLE;
                end else begin
                    next_tmo = tmo - 32'h1;
                end
            end
            DT_RUN: begin
                if (exc_s) begin
                    next_run = 1'b0;
                end
                if (sclk_rise) begin
                    next_tmo = 32'(TIMEOUT_CYC);
                end else if (!sclk_s && tmo == 32'h0) begin
                    next_mxf = 1'b1;
                    next_run = 1'b0;
                end else begin
                    next_tmo = (tmo == 32'h0) ? tmo : tmo - 32'h1;
                end
                if (sclk_s && dir_write) begin
                    next_wclk = 1'b1;
                end
                if (sclk_fall) begin
                    if (dir_write) begin
                        // word taken at wclk rise; present next at its fall
                        next_dout = '{data: wdata_reg, parity: dba_odd_par(wdata_reg)};
                    end else begin
                        next_rd_word = din_s.data;
                    end
                    next_word_cnt = wcnt_hi ? word_cnt - 16'h1 : word_cnt;
                    if (word_cnt == 16'h0001) begin
                        next_run = 1'b0;
                    end
                end
                if (ebl_s) begin
                    next_dt = DT_WAIT_EBL;
                end
            end
            DT_WAIT_EBL: begin
                if (ebl_fall) begin
                    // drive strobes run at trailing edge of block pulse
                    run_next = run_o && !exc_s;
                    if (run_next && occ_s) begin
                        next_tmo = 32'(TIMEOUT_CYC);
                        next_dt = DT_RUN;
                    end else begin
                        next_run = 1'b0;
                        next_doe = 1'b0;
                        next_busy = 1'b0;
                        next_dt = DT_IDLE;
                    end
                end
                if (exc_s) begin
                    next_run = 1'b0;
                end
            end
            default: next_dt = DT_IDLE;
        endcase
    end

    // ************************************************************
    // software visible registers
    // ************************************************************
    always_comb begin
        next_deskew = deskew;
        next_wdata_reg = wdata_reg;
        next_cpe = cpe || (hs_done && hs_perr);
        next_rd_valid = rd_valid;
        if (reg_wr_i && reg_addr_i == DBA_REG_DESKEW) begin
            next_deskew = (reg_wdata_i[7:0] == 8'h00) ? 8'h01 : reg_wdata_i[7:0];
        end
        if (reg_wr_i && reg_addr_i == DBA_REG_WDATA) begin
            next_wdata_reg = reg_wdata_i[15:0];
        end
        if (reg_wr_i && reg_addr_i == DBA_REG_STAT && reg_wdata_i[DBA_ST_CPE]) begin
            next_cpe = hs_done && hs_perr;
        end
        // a finishing read wins over a new access clearing the flag
        if (hs_done && !ctl_addr_o.direction_line) begin
            next_rd_valid = 1'b1;
        end else if (wr_acc || wr_cmd) begin
            next_rd_valid = 1'b0;
        end
    end

    always_comb begin
        status = 32'h0000_0000;
        status[DBA_ST_BUSY] = busy;
        status[DBA_ST_MXF] = missed_transfer_error;
        status[DBA_ST_EXC] = exc_seen;
        status[DBA_ST_ATTENTION_LINE] = attention_line_s;
        status[DBA_ST_CPE] = cpe;
        status[DBA_ST_CBUSY] = hs_busy;
        status[DBA_ST_RDV] = rd_valid;
        status[DBA_ST_DIR] = dir_write;
        status[15:0] = word_cnt;
        next_rdata = 32'h0000_0000;
        if (reg_rd_i) begin
            case (reg_addr_i)
                DBA_REG_STAT: next_rdata = status;
                DBA_REG_RDATA: next_rdata = {status[31:16], hs_rdata};
                DBA_REG_DESKEW: next_rdata = {24'h000000, deskew};
                DBA_REG_WDATA: next_rdata = {16'h0000, wdata_reg};
                DBA_REG_RDWORD: next_rdata = {16'h0000, rd_word};
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            dt <= DT_IDLE;
            tmo <= 32'h0;
            run_o <= 1'b0;
            busy <= 1'b0;
            missed_transfer_error <= 1'b0;
            exc_seen <= 1'b0;
            write_clk_o <= 1'b0;
            data_oe_o <= 1'b0;
            data_o <= '0;
            word_cnt <= 16'h0000;
            rd_word <= 16'h0000;
            dir_write <= 1'b0;
            sclk_d <= 1'b0;
            ebl_d <= 1'b0;
            deskew <= DBA_DESKEW_RST;
            wdata_reg <= 16'h0000;
            cpe <= 1'b0;
            rd_valid <= 1'b0;
            reg_rdata_o <= 32'h0000_0000;
        end else begin
            dt <= next_dt;
            tmo <= next_tmo;
            run_o <= next_run;
            busy <= next_busy;
            missed_transfer_error <= next_mxf;
            exc_seen <= next_exc_seen;
            write_clk_o <= next_wclk;
            data_oe_o <= next_doe;
            data_o <= next_dout;
            word_cnt <= next_word_cnt;
            rd_word <= next_rd_word;
            dir_write <= next_dir_write;
            sclk_d <= sclk_s;
            ebl_d <= ebl_s;
            deskew <= next_deskew;
            wdata_reg <= next_wdata_reg;
            cpe <= next_cpe;
            rd_valid <= next_rd_valid;
            reg_rdata_o <= next_rdata;
        end
    end
endmodule : dba_top

// ---- verif/dba_top_asserts.sv ----
// port checker for the drive bus adapter
`timescale 1ns/1ps
module dba_chk
    import dba_pkg::*;
(
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    input wire dba_addr_t ctl_addr_o,
    input wire dba_word_t ctl_o,
    input wire logic ctl_oe_o,
    input wire logic demand_strobe_o,
    input wire logic transfer_ack_i,
    input wire logic run_o,
    input wire logic occupied_line_i,
    input wire logic exception_line_i,
    input wire logic sync_clk_i,
    input wire logic write_clk_o,
    input wire logic data_oe_o
);
    // ****
    // properties
    // ****
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    sequence ack_seen;
        demand_strobe_o && transfer_ack_i;
    endsequence
    sequence exc_held;
        exception_line_i [*4];
    endsequence
    ctl_parity_a: assert property (ctl_oe_o |-> ctl_o.parity == ~^ctl_o.data)
        else $error("control parity not odd");
    addr_settled_a: assert property ($rose(demand_strobe_o) |-> $stable(ctl_addr_o))
        else $error("select lines moved at demand");
    write_data_a: assert property (demand_strobe_o && ctl_addr_o.direction_line |-> ctl_oe_o)
        else $error("write demand without data");
    read_float_a: assert property (demand_strobe_o && !ctl_addr_o.direction_line |-> !ctl_oe_o)
        else $error("adapter drives lines on read");
    demand_release_a: assert property (ack_seen |-> ##[1:300] !demand_strobe_o)
        else $error("demand not released after ack");
    exc_drop_a: assert property (exc_held |=> !run_o)
        else $error("run kept during exception");
    run_after_occ_a: assert property ($rose(run_o) |-> $past(occupied_line_i, 2))
        else $error("run without occupied");
    wclk_echo_a: assert property ($rose(write_clk_o) |-> sync_clk_i && data_oe_o)
        else $error("write clock not an echo");
    read_answer_a: assert property (reg_rdata_o != 32'h0 |-> $past(reg_rd_i))
        else $error("read data outside its cycle");
endmodule : dba_chk

bind dba_top dba_chk dba_chk_inst (.*);

// ---- verif/dba_drive_model.sv ----
// behavioural drive on the far side of the adapter
`timescale 1ns/1ps
module dba_drive_model
    import dba_pkg::*;
(
    input wire dba_addr_t ctl_addr_i,
    input wire dba_word_t ctl_in_i,
    input wire logic demand_i,
    input wire logic run_i,
    input wire logic wclk_i,
    input wire dba_word_t dout_i,
    input wire logic exc_req_i,
    input wire logic dead_i,
    output dba_word_t ctl_o,
    output logic ack_o,
    output logic attention_line_o,
    output logic occ_o,
    output logic exc_o,
    output logic eob_o,
    output logic sclk_o,
    output dba_word_t din_o
);
    // ****
    // registers, handshake, sectors
    // ****
    localparam int SECT = 4; // words a sector, arbitrary
    logic [15:0] regs [0:255];
    logic [15:0] wlast = 16'h0;
    logic [7:0] ra;
    int nw = 0;
    initial begin
        {ack_o, attention_line_o, occ_o, exc_o, eob_o, sclk_o} = 6'h0;
        ctl_o = '0;
        din_o = '0;
        for (int i = 0; i < 256; i++) regs[i] = 16'h0;
    end
    always @(posedge wclk_i) wlast = dout_i.data;
    task automatic xfer();
        if (dead_i) return;
        #40 occ_o = 1'b1;
        wait (run_i);
        do begin
            for (int i = 0; i < SECT; i++) begin
                if (exc_req_i && i == 1) exc_o = 1'b1;
                #20 sclk_o = 1'b1;
                din_o = {16'h1000 + nw[15:0], ~^(16'h1000 + nw[15:0])};
                #80 sclk_o = 1'b0;
                nw++;
                #60;
            end
            eob_o = 1'b1;
            #2000 eob_o = 1'b0;
        end while (run_i);
        exc_o = 1'b0;
        occ_o = 1'b0;
        din_o = ~din_o;
    endtask : xfer
    always @(posedge demand_i) begin
        ra = {ctl_addr_i.drive_select, ctl_addr_i.register_select};
        #15;
        if (!ctl_addr_i.direction_line) ctl_o = {regs[ra], ~^regs[ra]};
        else if (occ_o && ra[4:0] != 5'h03 && ra[4:0] != 5'h04) regs[8'h02][0] = 1'b1;
        else begin
            regs[ra] = ctl_in_i.data;
            if (ra[4:0] == 5'h00 && ctl_in_i.data[0]) begin
                if (ctl_in_i.data[5:0] >= DBA_DATA_CMD_MIN) fork xfer(); join_none
                else begin
                    if (ctl_in_i.data[5:0] == 6'h03) regs[8'h02][1] = 1'b1;
                    attention_line_o = 1'b1;
                end
            end
        end
        ack_o = 1'b1;
        wait (!demand_i);
        #15 ack_o = 1'b0;
        ctl_o = ~ctl_o; // released lines keep no stale value
    end
endmodule : dba_drive_model

// ---- verif/dba_top_bench.sv ----
// self-checking bench for the drive bus adapter
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin error_cnt++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
module dba_top_bench
    import dba_pkg::*;
;
    // ****
    // harness and sequence
    // ****
    logic mclk_i = 1'b0, sys_rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic [3:0] reg_addr_i = 4'h0;
    logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o;
    logic exc_req = 1'b0, dead = 1'b0;
    logic ack, attention_line, occupied_line, exception_line, eob, sclk, run, wclk, oe, doe, demand_strobe;
    dba_addr_t ca;
    dba_word_t ci, co, di, dout;
    int error_cnt = 0, n_checks = 0, cyc = 0;
    always #2.5 mclk_i = ~mclk_i;
    dba_top #(.TIMEOUT_CYC(200)) dba_top_inst (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .ctl_addr_o(ca), .ctl_i(ci),
        .ctl_o(co), .ctl_oe_o(oe), .demand_strobe_o(demand_strobe), .transfer_ack_i(ack),
        .attention_line_i(attention_line), .run_o(run), .occupied_line_i(occupied_line),
        .exception_line_i(exception_line), .end_of_block_pulse_i(eob), .sync_clk_i(sclk),
        .write_clk_o(wclk), .data_i(di), .data_o(dout), .data_oe_o(doe));
    dba_drive_model dba_drive_model_inst (.ctl_addr_i(ca), .ctl_in_i(co), .demand_i(demand_strobe),
        .run_i(run), .wclk_i(wclk), .dout_i(dout), .exc_req_i(exc_req), .dead_i(dead),
        .ctl_o(ci), .ack_o(ack), .attention_line_o(attention_line), .occ_o(occupied_line), .exc_o(exception_line), .eob_o(eob),
        .sclk_o(sclk), .din_o(di));
    task automatic summarize();
        $display("checks=%0d mismatches=%0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : summarize
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 60000) begin
            error_cnt++;
            summarize();
        end
    end
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge mclk_i);
        reg_wr_i <= 1'b0;
        @(posedge mclk_i);
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge mclk_i);
        reg_rd_i <= 1'b0;
        #1 d = reg_rdata_o;
        @(posedge mclk_i);
    endtask : rd
    task automatic wait_clr(input int b, input int lim);
        logic [31:0] s;
        s = '1;
        for (int i = 0; i < lim && s[b] !== 1'b0; i++) rd(DBA_REG_STAT, s);
        `CHK(s[b], 1'b0)
    endtask : wait_clr
    task automatic drv_rd(input logic [15:0] sel, input logic [15:0] e);
        logic [31:0] v;
        wr(DBA_REG_ACC, {16'h0, sel});
        wait_clr(DBA_ST_CBUSY, 200);
        rd(DBA_REG_RDATA, v);
        `CHK(v[15:0], e)
    endtask : drv_rd
    initial begin
        logic [31:0] v, s;
        repeat (5) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        @(posedge mclk_i);
        rd(DBA_REG_DESKEW, v);
        `CHK(v[7:0], 8'h0a)
        wr(DBA_REG_DESKEW, 32'h0);
        rd(DBA_REG_DESKEW, v);
        `CHK(v[7:0], 8'h01)
        wr(DBA_REG_DESKEW, 32'h3);
        rd(4'hf, v);
        `CHK(v, 32'h0)
        wr(DBA_REG_WDATA, 32'h1234);
        wr(DBA_REG_ACC, 32'h00010205);
        wait_clr(DBA_ST_CBUSY, 200);
        drv_rd(16'h0205, 16'h1234);
        rd(DBA_REG_RDATA, v);
        `CHK(v, (32'h1 << DBA_ST_RDV) | 32'h0000_1234)
        rd(DBA_REG_STAT, s);
        `CHK(s[DBA_ST_CPE], 1'b0)
        wr(DBA_REG_CMD, 32'h5);
        wait_clr(DBA_ST_CBUSY, 200);
        rd(DBA_REG_STAT, s);
        `CHK(s[DBA_ST_ATTENTION_LINE], 1'b1)
        wr(DBA_REG_CMD, 32'h3);
        wait_clr(DBA_ST_CBUSY, 200);
        wr(DBA_REG_CMD, 32'h00080039);
        @(posedge mclk_i);
        rd(DBA_REG_STAT, s);
        `CHK(s[DBA_ST_BUSY], 1'b1)
        wait_clr(DBA_ST_CBUSY, 200);
        drv_rd(16'h0205, 16'h1234);
        wait_clr(DBA_ST_BUSY, 3000);
        rd(DBA_REG_RDWORD, v);
        `CHK(v[15:0], 16'h1007)
        wr(DBA_REG_WDATA, 32'hbeef);
        wr(DBA_REG_CMD, 32'h00050031);
        wait_clr(DBA_ST_CBUSY, 200);
        wr(DBA_REG_ACC, 32'h00010005);
        wait_clr(DBA_ST_BUSY, 3000);
        `CHK(dba_drive_model_inst.wlast, 16'hbeef)
        drv_rd(16'h0005, 16'h0000);
        drv_rd(16'h0002, 16'h0003);
        exc_req <= 1'b1;
        wr(DBA_REG_CMD, 32'h000c0039);
        wait_clr(DBA_ST_BUSY, 3000);
        rd(DBA_REG_STAT, s);
        `CHK(s[DBA_ST_EXC], 1'b1)
        `CHK(s[15:0], 16'h0008)
        exc_req <= 1'b0;
        dead <= 1'b1;
        wr(DBA_REG_CMD, 32'h00020039);
        wait_clr(DBA_ST_BUSY, 500);
        rd(DBA_REG_STAT, s);
        `CHK(s[DBA_ST_MXF], 1'b1)
        summarize();
    end
endmodule : dba_top_bench
